// ---- pkg/prr_pkg.sv ----
// constants for the pace and respiration result readout
package prr_pkg;
  localparam logic [7:0]  ADDR_PACE      = 8'h1A;
  localparam logic [7:0]  ADDR_RESP_MAG  = 8'h1B;
  localparam logic [7:0]  ADDR_RESP_PH   = 8'h1C;
  localparam int          PACE_CH        = 3;
  localparam int          GRP_W          = 8;
  localparam int          FLAG_POS       = 7;
  localparam int          WID_LSB        = 4;
  localparam int          WID_W          = 3;
  localparam int          HGT_W          = 4;
  localparam int          DATA_W         = 24;
  localparam int          WORD_W         = 32;
  localparam int          HALF_W         = 16;
  localparam logic [23:0] DATA_RESET     = 24'h000000;
  localparam int          CLK_HZ         = 125000000;
  localparam int          RATE_HZ        = 128000;
  // accumulator step so the enable averages 128 kHz from 125 MHz
  localparam logic [16:0] ACC_MOD        = 17'h1E848;
  localparam logic [16:0] ACC_STEP       = 17'h00080;
  localparam int          WID_CNT_W      = 16;
  localparam int          AMP_W          = 16;
  typedef enum logic [1:0]
  {
    SH_IDLE  = 2'b00,
    SH_SHIFT = 2'b01
  } prr_shift_t;
endpackage : prr_pkg

// ---- rtl/prr_readout.sv ----
// pace result packing, respiration words and serial word readout
`timescale 1ns/1ps
module prr_readout
  import prr_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 resetn,
  input  wire logic [PACE_CH-1:0]   pace_pulse,
  input  wire logic [AMP_W-1:0]     pace_amp [PACE_CH],
  input  wire logic                 frame_start,
  input  wire logic                 resp_valid,
  input  wire logic [DATA_W-1:0]    resp_mag_in,
  input  wire logic [DATA_W-1:0]    resp_ph_in,
  input  wire logic                 rd_req,
  input  wire logic [7:0]           rd_addr,
  input  wire logic                 frame_mode,
  input  wire logic                 half_sel,
  output logic                      rate_tick,
  output logic [DATA_W-1:0]         pace_detect_result,
  output logic [DATA_W-1:0]         respiration_magnitude,
  output logic [DATA_W-1:0]         respiration_phase,
  output logic                      sdo,
  output logic                      sdo_valid,
  output logic                      sdo_last
);

  // log2 floor of a nonzero value, zero for zero
  function automatic logic [4:0] prr_log2(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++)
      if (v[i])
        r = 5'(i);
    return r;
  endfunction : prr_log2

  function automatic logic [WID_W-1:0] prr_wcode(input logic [15:0] w);
    logic [4:0] l;
    l = prr_log2(w);
    if (l == 5'h00)
      return '0;
    else if (l > 5'h08)
      return 3'h7;
    else
      return 3'(l - 5'h01);
  endfunction : prr_wcode

  // 128 kHz tick from an accumulator divider
  logic [16:0] acc_ff, nxt_acc;
  logic        tick_ff, nxt_tick;
  always_comb
  begin
    nxt_acc  = acc_ff + ACC_STEP;
    nxt_tick = 1'b0;
    if (nxt_acc >= ACC_MOD)
    begin
      nxt_acc  = 17'(nxt_acc - ACC_MOD);
      nxt_tick = 1'b1;
    end
  end
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      acc_ff  <= 17'h00000;
      tick_ff <= 1'b0;
    end
    else
    begin
      acc_ff  <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end
  assign rate_tick = tick_ff;

  // per-channel measurement and frame latch
  logic [PACE_CH-1:0]   prev_ff, nxt_prev;
  logic [WID_CNT_W-1:0] wcnt_ff [PACE_CH], nxt_wcnt [PACE_CH];
  logic [AMP_W-1:0]     peak_ff [PACE_CH], nxt_peak [PACE_CH];
  logic [DATA_W-1:0]    pace_ff, nxt_pace;
  logic [PACE_CH-1:0]   trail;
  always_comb
  begin
    nxt_prev = pace_pulse;
    nxt_pace = frame_start ? DATA_RESET : pace_ff;
    for (int c = 0; c < PACE_CH; c++)
    begin
      trail[c]    = prev_ff[c] && !pace_pulse[c];
      nxt_wcnt[c] = wcnt_ff[c];
      nxt_peak[c] = peak_ff[c];
      if (pace_pulse[c] && !prev_ff[c])
      begin
        nxt_wcnt[c] = '0;
        nxt_peak[c] = pace_amp[c];
      end
      else if (pace_pulse[c])
      begin
        if (tick_ff && wcnt_ff[c] != '1)
          nxt_wcnt[c] = wcnt_ff[c] + 16'h0001;
        if (pace_amp[c] > peak_ff[c])
          nxt_peak[c] = pace_amp[c];
      end
      if (trail[c])
      begin
        // detection wins over a frame clear in the same cycle
        nxt_pace[c*GRP_W+FLAG_POS] = 1'b1;
        nxt_pace[c*GRP_W+WID_LSB +: WID_W] = prr_wcode(wcnt_ff[c]);
        nxt_pace[c*GRP_W +: HGT_W] = 4'(prr_log2(peak_ff[c]));
      end
    end
  end
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      prev_ff <= '0;
      pace_ff <= DATA_RESET;
      for (int c = 0; c < PACE_CH; c++)
      begin
        wcnt_ff[c] <= '0;
        peak_ff[c] <= '0;
      end
    end
    else
    begin
      prev_ff <= nxt_prev;
      pace_ff <= nxt_pace;
      wcnt_ff <= nxt_wcnt;
      peak_ff <= nxt_peak;
    end
  end
  assign pace_detect_result = pace_ff;

  // respiration words held as delivered
  logic [DATA_W-1:0] mag_ff, nxt_mag, ph_ff, nxt_ph;
  always_comb
  begin
    nxt_mag = resp_valid ? resp_mag_in : mag_ff;
    nxt_ph  = resp_valid ? resp_ph_in  : ph_ff;
  end
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      mag_ff <= DATA_RESET;
      ph_ff  <= DATA_RESET;
    end
    else
    begin
      mag_ff <= nxt_mag;
      ph_ff  <= nxt_ph;
    end
  end
  assign respiration_magnitude = mag_ff;
  assign respiration_phase     = ph_ff;

  // serial shifter: address byte then data, msb first; the frame-mode low half (half_sel) is data bits 15:0 only
  prr_shift_t        st_ff, nxt_st;
  logic [WORD_W-1:0] sh_ff, nxt_sh;
  logic [5:0]        cnt_ff, nxt_cnt;
  logic              sdo_ff, nxt_sdo, sv_ff, nxt_sv, sl_ff, nxt_sl;
  logic [DATA_W-1:0] sel_data;
  logic [WORD_W-1:0] word;
  always_comb
  begin
    unique case (rd_addr)
      ADDR_PACE:     sel_data = pace_ff;
      ADDR_RESP_MAG: sel_data = mag_ff;
      ADDR_RESP_PH:  sel_data = ph_ff;
      default:       sel_data = DATA_RESET;
    endcase
    word    = {rd_addr, sel_data};
    nxt_st  = st_ff;
    nxt_sh  = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_sdo = 1'b0;
    nxt_sv  = 1'b0;
    nxt_sl  = 1'b0;
    unique case (st_ff)
      SH_IDLE:
        if (rd_req)
        begin
          nxt_st = SH_SHIFT;
          if (frame_mode)
          begin
            // frame mode: one 16-bit half per request
            nxt_sh  = half_sel ? {word[HALF_W-1:0], 16'h0000}
                               : word;
            nxt_cnt = 6'(HALF_W);
          end
          else
          begin
            nxt_sh  = word;
            nxt_cnt = 6'(WORD_W);
          end
        end
      SH_SHIFT:
      begin
        nxt_sdo = sh_ff[WORD_W-1];
        nxt_sv  = 1'b1;
        nxt_sh  = {sh_ff[WORD_W-2:0], 1'b0};
        nxt_cnt = 6'(cnt_ff - 6'h01);
        if (cnt_ff == 6'h01)
        begin
          nxt_sl = 1'b1;
          nxt_st = SH_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      st_ff  <= SH_IDLE;
      sh_ff  <= '0;
      cnt_ff <= 6'h00;
      sdo_ff <= 1'b0;
      sv_ff  <= 1'b0;
      sl_ff  <= 1'b0;
    end
    else
    begin
      st_ff  <= nxt_st;
      sh_ff  <= nxt_sh;
      cnt_ff <= nxt_cnt;
      sdo_ff <= nxt_sdo;
      sv_ff  <= nxt_sv;
      sl_ff  <= nxt_sl;
    end
  end
  assign sdo       = sdo_ff;
  assign sdo_valid = sv_ff;
  assign sdo_last  = sl_ff;

  // properties on the pace word, the readout framing and the captures
  chk_flag_on_trail: assert property (
    @(posedge clock) disable iff (!resetn)
    prev_ff[0] && !pace_pulse[0] |=> pace_ff[FLAG_POS])
    else $error("pace flag not set after trailing edge");

  chk_top_group_flag: assert property (
    @(posedge clock) disable iff (!resetn)
    prev_ff[2] && !pace_pulse[2] |=> pace_ff[2*GRP_W+FLAG_POS])
    else $error("channel three flag not in top byte");

  chk_frame_clear: assert property (
    @(posedge clock) disable iff (!resetn)
    frame_start && !(prev_ff[0] && !pace_pulse[0]) |=> !pace_ff[FLAG_POS])
    else $error("pace flag not cleared at frame start");

  chk_full_word_len: assert property (
    @(posedge clock) disable iff (!resetn)
    st_ff == SH_IDLE && rd_req && !frame_mode |=> ##1 sdo_valid [*8])
    else $error("full word read too short");

  chk_full_word_end: assert property (
    @(posedge clock) disable iff (!resetn)
    st_ff == SH_IDLE && rd_req && !frame_mode |=> ##32 sdo_last)
    else $error("full word read not 32 bits");

  chk_idle_quiet: assert property (
    @(posedge clock) disable iff (!resetn)
    st_ff == SH_IDLE |=> !sdo_valid)
    else $error("bit shown while shifter idle");

  chk_half_word_end: assert property (
    @(posedge clock) disable iff (!resetn)
    st_ff == SH_IDLE && rd_req && frame_mode |=> ##16 sdo_last)
    else $error("frame half word not 16 bits");

  chk_addr_first: assert property (
    @(posedge clock) disable iff (!resetn)
    st_ff == SH_IDLE && rd_req && rd_addr == ADDR_PACE && !frame_mode
    |=> ##4 sdo)
    else $error("address byte bit wrong");

  chk_mag_capture: assert property (
    @(posedge clock) disable iff (!resetn)
    resp_valid |=> respiration_magnitude == $past(resp_mag_in))
    else $error("magnitude not captured");

  chk_phase_capture: assert property (
    @(posedge clock) disable iff (!resetn)
    resp_valid |=> respiration_phase == $past(resp_ph_in))
    else $error("phase not captured");

  chk_flag_stable: assert property (
    @(posedge clock) disable iff (!resetn)
    !frame_start && pace_ff[FLAG_POS] |=> pace_ff[FLAG_POS])
    else $error("pace flag dropped within frame");

  chk_tick_single: assert property (
    @(posedge clock) disable iff (!resetn)
    rate_tick |=> !rate_tick)
    else $error("rate tick longer than one cycle");
endmodule : prr_readout

// ---- tb/prr_host.sv ----
// host-side serial receiver model for the readout shifter
`timescale 1ns/1ps
module prr_host
(
  input  wire logic        clock,
  input  wire logic        rd_req,
  input  wire logic        sdo,
  input  wire logic        sdo_valid,
  input  wire logic        sdo_last,
  output logic [31:0]      word_ff,
  output logic [5:0]       bits_ff,
  output logic             done_ff
);
  // takes bits msb first; a new request clears the count and done
  always_ff @(posedge clock)
  begin
    if (rd_req)
    begin
      bits_ff <= 6'h00;
      done_ff <= 1'b0;
    end
    else if (sdo_valid)
    begin
      word_ff <= {word_ff[30:0], sdo};
      bits_ff <= bits_ff + 6'h01;
      done_ff <= sdo_last;
    end
  end
endmodule : prr_host

// ---- tb/pace_resp_result_readout_tb.sv ----
// bench for the pace and respiration result readout
`timescale 1ns/1ps
module pace_resp_result_readout_tb;
  import prr_pkg::*;
`define CHK(n, e, g) begin num_checks++; if ((e) !== (g)) begin \
  failures++; $display("ERROR %s expected %h seen %h", n, e, g); end end
  logic               clock;
  logic               resetn;
  logic [2:0]         pace_pulse;
  logic [AMP_W-1:0]   amp [PACE_CH];
  logic               frame_start;
  logic               resp_valid;
  logic [DATA_W-1:0]  mag_in;
  logic [DATA_W-1:0]  ph_in;
  logic               rd_req;
  logic [7:0]         rd_addr;
  logic               frame_mode;
  logic               half_sel;
  logic [DATA_W-1:0]  pace_w;
  logic [DATA_W-1:0]  mag;
  logic [DATA_W-1:0]  ph;
  logic               sdo;
  logic               sdo_valid;
  logic               sdo_last;
  logic [31:0]        word;
  logic [5:0]         bits;
  logic               done;
  logic [31:0]        w;
  int                 failures;
  int                 num_checks;
  logic               tick;
  logic               tick_ok;
  int                 tick_cnt = 0;
  int                 tick_gap = 0;

  prr_readout dut_u (.clock(clock), .resetn(resetn),
    .pace_pulse(pace_pulse), .pace_amp(amp), .frame_start(frame_start),
    .resp_valid(resp_valid), .resp_mag_in(mag_in), .resp_ph_in(ph_in),
    .rd_req(rd_req), .rd_addr(rd_addr), .frame_mode(frame_mode),
    .half_sel(half_sel), .rate_tick(tick), .pace_detect_result(pace_w),
    .respiration_magnitude(mag), .respiration_phase(ph), .sdo(sdo),
    .sdo_valid(sdo_valid), .sdo_last(sdo_last));

  prr_host host_u (.clock(clock), .rd_req(rd_req), .sdo(sdo),
    .sdo_valid(sdo_valid), .sdo_last(sdo_last), .word_ff(word),
    .bits_ff(bits), .done_ff(done));

  // cycles between the last two rate ticks
  always @(posedge clock)
    if (tick === 1'b1)
    begin
      tick_gap <= tick_cnt;
      tick_cnt <= 1;
    end
    else
      tick_cnt <= tick_cnt + 1;

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task end_sim;
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task rd(input logic [7:0] a, input logic fm, input logic hs);
    int i;
    @(posedge clock);
    rd_req <= 1'b1;
    rd_addr <= a;
    frame_mode <= fm;
    half_sel <= hs;
    @(posedge clock);
    rd_req <= 1'b0;
    #1;
    for (i = 0; i < 60 && done !== 1'b1; i++)
    begin
      @(posedge clock);
      #1;
    end
    w = word;
    `CHK("bits", fm ? 6'h10 : 6'h20, bits)
  endtask : rd

  // pulse high for len+1 cycles on one channel, then let it end
  task pulse(input int ch, input logic [15:0] a, input int len);
    @(posedge clock);
    pace_pulse[ch] <= 1'b1;
    amp[ch] <= a;
    repeat (len) @(posedge clock);
    #1;
    `CHK("flag_early", 1'b0, pace_w[8*ch+7])
    @(posedge clock);
    pace_pulse[ch] <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask : pulse

  initial
  begin
    failures = 0;
    num_checks = 0;
    resetn = 1'b0;
    pace_pulse = 3'h0;
    amp = '{16'h0000, 16'h0000, 16'h0000};
    frame_start = 1'b0;
    resp_valid = 1'b0;
    mag_in = 24'h000000;
    ph_in = 24'h000000;
    rd_req = 1'b0;
    rd_addr = 8'h00;
    frame_mode = 1'b0;
    half_sel = 1'b0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    #1;
    `CHK("pace_rst", 24'h000000, pace_w)
    `CHK("mag_rst", 24'h000000, mag)
    pulse(0, 16'h0005, 1);
    `CHK("pace_c1", 24'h000082, pace_w)
    pulse(1, 16'h0001, 1);
    `CHK("pace_c2", 24'h008082, pace_w)
    pulse(2, 16'h8000, 5000);
    `CHK("pace_c3", 24'h9F8082, pace_w)
    // tick spacing must average the 128 kHz rate
    tick_ok = (tick_gap == CLK_HZ / RATE_HZ) ||
              (tick_gap == CLK_HZ / RATE_HZ + 1);
    `CHK("tick_gap", 1'b1, tick_ok)
    rd(ADDR_PACE, 1'b0, 1'b0);
    `CHK("rd_pace", 32'h1A9F8082, w)
    rd(ADDR_PACE, 1'b1, 1'b0);
    `CHK("rd_hi", 16'h1A9F, w[15:0])
    rd(ADDR_PACE, 1'b1, 1'b1);
    `CHK("rd_lo", 16'h8082, w[15:0])
    @(posedge clock);
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK("pace_clr", 24'h000000, pace_w)
    // trailing edge in the frame-start cycle survives the clear
    @(posedge clock);
    pace_pulse[1] <= 1'b1;
    @(posedge clock);
    pace_pulse[1] <= 1'b0;
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    @(posedge clock);
    #1;
    `CHK("pace_race", 24'h008000, pace_w)
    @(posedge clock);
    resp_valid <= 1'b1;
    mag_in <= 24'hABCDEF;
    ph_in <= 24'hC00000;
    @(posedge clock);
    resp_valid <= 1'b0;
    #1;
    `CHK("mag", 24'hABCDEF, mag)
    `CHK("ph", 24'hC00000, ph)
    rd(ADDR_RESP_MAG, 1'b0, 1'b0);
    `CHK("rd_mag", 32'h1BABCDEF, w)
    rd(ADDR_RESP_PH, 1'b0, 1'b0);
    `CHK("rd_ph", 32'h1CC00000, w)
    rd(8'h20, 1'b0, 1'b0);
    `CHK("rd_unmapped", 32'h20000000, w)
    // precise width and height words live outside this block
    rd(8'h3A, 1'b0, 1'b0);
    `CHK("rd_precise", 32'h3A000000, w)
    end_sim;
  end

  // cuts a hang short well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    end_sim;
  end
endmodule : pace_resp_result_readout_tb
